// *** hw/bsf_cfg.svh ***
// Constants for the bit-set-in-file instruction unit.
// Assumes inclusion by bare name from the design files.
`ifndef BFI_CFG_SVH
`define BFI_CFG_SVH
// ==========================================================
// Encoding
`define BFI_OPCODE 4'h8
`define BFI_OP_HI 15
`define BFI_OP_LO 12
`define BFI_BIT_HI 11
`define BFI_BIT_LO 9
`define BFI_ACC_POS 8
`define BFI_ADR_HI 7
`define BFI_ADR_LO 0
// ==========================================================
// Addressing
`define BFI_IDX_LIMIT 8'h5f
`define BFI_ACC_HI_BANK 4'hf
`define BFI_ACC_SPLIT 8'h60
// ==========================================================
// Register bus offsets (byte addresses) and control register bit positions
`define BFI_REG_INSTR 4'h0
`define BFI_REG_CTRL 4'h4
`define BFI_REG_STAT 4'h8
`define BFI_REG_RESULT 4'hc
`define BFI_CTRL_BANK_LO 0
`define BFI_CTRL_XINST 8
`define BFI_CTRL_BASE_LO 16
`endif

// *** hw/bsf_pkg.sv ***
// Types for the bit-set-in-file instruction unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bfi_pkg;
	// ==========================================================
	// Quarter-cycle phases
	typedef enum logic [3:0] {
		BFI_Q1 = 4'b0001,
		BFI_Q2 = 4'b0010,
		BFI_Q3 = 4'b0100,
		BFI_Q4 = 4'b1000
	} bfi_phase_e;
	typedef logic [11:0] bfi_addr_t;
endpackage : bfi_pkg

// *** hw/bsf_bit_set.sv ***
// Sets one selected bit of a byte, leaves the rest.
// Assumes a plain combinational context.
`timescale 1ns/100ps
module bfi_bit_set
(
	input wire logic [7:0] din,
	input wire logic [2:0] bit_idx,
	output logic [7:0] dout
);
	// ==========================================================
	// Mask or
	always_comb
	begin
		dout = din | (8'h01 << bit_idx);
	end
endmodule : bfi_bit_set

// *** hw/bsf_core.sv ***
// Bit-set-in-file instruction unit with Avalon-MM register slave.
// Assumes a data memory port that answers reads combinationally.
//
// Contract
// - Opcode 1000, then bit, access, address
// - Set chosen bit only, no flags
// - Access bit zero uses quick-access bank
// - Access bit one uses bank select
// - Extended set, low address: indexed offset
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "bsf_cfg.svh"
module bfi_core
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [11:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic busy
);
	// ==========================================================
	// Registers
	logic [15:0] instr_r;
	logic [3:0] bank_sel_r;
	logic xinst_r;
	logic [11:0] idx_base_r;
	logic start_r;
	logic done_r;
	logic illegal_r;
	logic [7:0] result_r;
	logic [7:0] rd_data_r;
	logic [11:0] addr_r;
	logic [7:0] mod_data;
	logic rsp_r;
	logic [31:0] rdata_r;
	bfi_pkg::bfi_phase_e phase_r;
	bfi_pkg::bfi_phase_e phase_nxt;
	logic active_r;
	logic is_op;
	logic acc_bit;
	logic [7:0] f_adr;
	logic [2:0] bit_idx;
	bfi_pkg::bfi_addr_t eff_addr;
	bfi_pkg::bfi_addr_t idx_addr;
	bfi_pkg::bfi_addr_t quick_addr;
	bfi_pkg::bfi_addr_t bank_addr;
	logic [31:0] rd_mux;
	logic wr_ok;
	logic instr_hit;
	logic ctrl_hit;

	// ==========================================================
	// Bus slave: one wait state per access
	always_comb
	begin
		avs_waitrequest = (avs_read | avs_write) & ~rsp_r;
	end

	// Toggle gives exactly one wait state, so no request can starve
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			rsp_r <= 1'b0;
		else
			rsp_r <= (avs_read | avs_write) & ~rsp_r;
	end

	// Writes take effect on the edge waitrequest is low
	always_comb
	begin
		wr_ok = avs_write & rsp_r;
		instr_hit = wr_ok & (avs_address == `BFI_REG_INSTR);
		ctrl_hit = wr_ok & (avs_address == `BFI_REG_CTRL);
	end

	// ==========================================================
	// Read path
	always_comb
	begin
		case (avs_address)
			`BFI_REG_INSTR: rd_mux = {16'h0000, instr_r};
			`BFI_REG_CTRL: rd_mux = {4'h0, idx_base_r, 7'h00, xinst_r, 4'h0, bank_sel_r};
			`BFI_REG_STAT: rd_mux = {29'h0, illegal_r, done_r, active_r};
			`BFI_REG_RESULT: rd_mux = {24'h0, result_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Captured in the wait cycle so data stand when waitrequest drops
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			rdata_r <= 32'h0000_0000;
		else if (avs_read & ~rsp_r)
			rdata_r <= rd_mux;
	end

	always_comb
	begin
		avs_readdata = rdata_r;
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			start_r <= 1'b0;
		else
			start_r <= instr_hit & ~active_r;
	end

	// Launch refused while busy; instruction word stays
	// Lanes 2 and 3 of the instruction word are ignored
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			instr_r <= 16'h0000;
		else if (instr_hit && !active_r)
		begin
			if (avs_byteenable[0])
				instr_r[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				instr_r[15:8] <= avs_writedata[15:8];
		end
	end

	// Changing control mid-instruction is allowed; address is latched
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			bank_sel_r <= 4'h0;
			xinst_r <= 1'b0;
			idx_base_r <= 12'h000;
		end
		else if (ctrl_hit)
		begin
			if (avs_byteenable[0])
				bank_sel_r <= avs_writedata[3:0];
			if (avs_byteenable[1])
				xinst_r <= avs_writedata[`BFI_CTRL_XINST];
			if (avs_byteenable[2])
				idx_base_r[7:0] <= avs_writedata[23:16];
			if (avs_byteenable[3])
				idx_base_r[11:8] <= avs_writedata[27:24];
		end
	end

	// ==========================================================
	// Decode
	always_comb
	begin
		is_op = instr_r[`BFI_OP_HI:`BFI_OP_LO] == `BFI_OPCODE;
		bit_idx = instr_r[`BFI_BIT_HI:`BFI_BIT_LO];
		acc_bit = instr_r[`BFI_ACC_POS];
		f_adr = instr_r[`BFI_ADR_HI:`BFI_ADR_LO];
	end

	// ==========================================================
	// Address forming
	// Indexed sum wraps within the 12-bit data space
	always_comb
	begin
		idx_addr = 12'(idx_base_r + {4'h0, f_adr});
		bank_addr = {bank_sel_r, f_adr};
		// Low part maps to bank 0, upper part to the special-function bank
		if (f_adr < `BFI_ACC_SPLIT)
			quick_addr = {4'h0, f_adr};
		else
			quick_addr = {`BFI_ACC_HI_BANK, f_adr};
	end

	// Indexed mode wins over the quick-access bank for low addresses
	always_comb
	begin
		if (!acc_bit && xinst_r && f_adr <= `BFI_IDX_LIMIT)
			eff_addr = idx_addr;
		else if (!acc_bit)
			eff_addr = quick_addr;
		else
			eff_addr = bank_addr;
	end

	// ==========================================================
	// Phase sequencer
	always_comb
	begin
		case (phase_r)
			bfi_pkg::BFI_Q1: phase_nxt = bfi_pkg::BFI_Q2;
			bfi_pkg::BFI_Q2: phase_nxt = bfi_pkg::BFI_Q3;
			bfi_pkg::BFI_Q3: phase_nxt = bfi_pkg::BFI_Q4;
			bfi_pkg::BFI_Q4: phase_nxt = bfi_pkg::BFI_Q1;
			default: phase_nxt = bfi_pkg::BFI_Q1;
		endcase
	end

	// Decode phase is the start cycle itself
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			phase_r <= bfi_pkg::BFI_Q1;
		else if (start_r && is_op)
			phase_r <= bfi_pkg::BFI_Q2;
		else if (active_r)
			phase_r <= phase_nxt;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			active_r <= 1'b0;
		else if (start_r && is_op)
			active_r <= 1'b1;
		else if (active_r)
			active_r <= phase_r != bfi_pkg::BFI_Q4;
	end

	// ==========================================================
	// Datapath
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			addr_r <= 12'h000;
		else if (start_r && is_op)
			addr_r <= eff_addr;
	end

	// Memory answers combinationally, so Q2 sees the addressed byte
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			rd_data_r <= 8'h00;
		else if (active_r && phase_r == bfi_pkg::BFI_Q2)
			rd_data_r <= mem_rdata;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			result_r <= 8'h00;
		else if (active_r && phase_r == bfi_pkg::BFI_Q3)
			result_r <= mod_data;
	end

	bfi_bit_set u_set
	(
		.din(rd_data_r),
		.bit_idx(bit_idx),
		.dout(mod_data)
	);

	// ==========================================================
	// Completion status
	// Core status flags are never touched; done/illegal only
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			done_r <= 1'b0;
		else if (start_r)
			done_r <= 1'b0;
		else if (active_r && phase_r == bfi_pkg::BFI_Q4)
			done_r <= 1'b1;
	end

	// Bad opcode launches nothing, so no write can follow it
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			illegal_r <= 1'b0;
		else if (start_r)
			illegal_r <= ~is_op;
	end

	// ==========================================================
	// Outputs
	always_comb
	begin
		mem_addr = addr_r;
	end

	always_comb
	begin
		mem_wdata = result_r;
	end

	// Single write strobe per instruction, in the last phase
	always_comb
	begin
		mem_we = active_r & (phase_r == bfi_pkg::BFI_Q4);
	end

	always_comb
	begin
		busy = active_r;
	end
endmodule : bfi_core

// *** verification/bsf_core_checker.sv ***
// Port checker for the bit-set unit.
// Assumes bfi_core ports; bound below.
`timescale 1ns/100ps
module bfi_core_checker
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic busy
);
	// ==========
	// Shadow copies
	logic [15:0] ins_r;
	logic [27:0] ctl_r;
	logic go;
	logic [7:0] f;
	logic q;
	assign go = avs_write && !avs_waitrequest && avs_address == 4'h0 && !busy;
	assign f = ins_r[7:0];
	assign q = !ins_r[8] && !(ctl_r[8] && f <= 8'h5f);
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			ins_r <= 16'h0000;
			ctl_r <= 28'h0000000;
		end
		else
		begin
			if (go)
				ins_r <= avs_writedata[15:0];
			if (avs_write && !avs_waitrequest && avs_address == 4'h4)
				ctl_r <= avs_writedata[27:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_wb;
		mem_we ##1 !mem_we;
	endsequence
	a_op_decode: assert property (go && avs_writedata[15:12] != 4'h8 |=> !mem_we[*5])
		else $error("write after bad opcode");
	a_bit_only: assert property (mem_we |-> mem_wdata == ($past(mem_rdata, 2) | (8'h01 << ins_r[11:9])))
		else $error("wrong write byte");
	a_quick_bank: assert property (mem_we && q |-> mem_addr == {(f < 8'h60) ? 4'h0 : 4'hf, f})
		else $error("quick bank address");
	a_bank_sel: assert property (mem_we && ins_r[8] |-> mem_addr == {ctl_r[3:0], f})
		else $error("banked address");
	a_index_off: assert property (mem_we && !ins_r[8] && ctl_r[8] && f <= 8'h5f |-> mem_addr == ctl_r[27:16] + {4'h0, f})
		else $error("indexed address");
	a_one_cycle: assert property (go && avs_writedata[15:12] == 4'h8 |-> ##[3:4] s_wb)
		else $error("write phase late");
endmodule : bfi_core_checker
bind bfi_core bfi_core_checker i_chk (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .busy(busy));

// *** verification/bsf_core_test.sv ***
// Bench for the bit-set unit over its register bus.
// Assumes bfi_core and its checker compiled first.
`timescale 1ns/100ps
module bit_set_file_instruction_test;
	logic ref_clk = 1'h0, resetn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, busy, mem_we;
	logic [11:0] mem_addr, ea;
	logic [7:0] mem_wdata, f, old;
	logic [7:0] mem [4096];
	wire [7:0] mem_rdata = mem[mem_addr];
	int error_cnt = 0, num_checks = 0;
	bfi_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .busy(busy));
	initial
		forever #50 ref_clk = ~ref_clk;
	initial
		foreach (mem[i]) mem[i] = 8'h0a;
	always @(posedge ref_clk)
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	// ==========
	// Tasks
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge ref_clk);
	endtask : bus
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		error_cnt++;
		end_sim;
	end
	// ==========
	// Tests: every bit index, all address modes
	initial
	begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		for (int b = 0; b < 8; b++)
		begin
			f = 8'h48 + 8'(b * 8);
			ea = b[0] ? {4'h3, f} : (b[1] && f <= 8'h5f) ? 12'h200 + {4'h0, f} : {(f < 8'h60) ? 4'h0 : 4'hf, f};
			old = mem[ea];
			bus(1'h1, 4'h4, {4'h0, 12'h200, 7'h0, b[1], 4'h0, 4'h3});
			bus(1'h0, 4'h4, 32'h0);
			chk("ctrl", rd, {4'h0, 12'h200, 7'h0, b[1], 4'h0, 4'h3});
			bus(1'h1, 4'h0, {16'h0, 4'h8, b[2:0], b[0], f});
			repeat (6) @(posedge ref_clk);
			chk("addr", {20'h0, mem_addr}, {20'h0, ea});
			chk("mem", {24'h0, mem[ea]}, {24'h0, old | (8'h01 << b)});
			bus(1'h0, 4'h8, 32'h0);
			chk("stat", rd, 32'h2);
			bus(1'h0, 4'hc, 32'h0);
			chk("result", rd, {24'h0, old | (8'h01 << b)});
			$display("op %0d done", b);
		end
		bus(1'h1, 4'h0, 32'h9e48);
		repeat (6) @(posedge ref_clk);
		bus(1'h0, 4'h8, 32'h0);
		chk("illegal", rd, 32'h4);
		$display("illegal done");
		bus(1'h1, 4'h0, 32'h8110);
		bus(1'h1, 4'h0, 32'h8e10);
		repeat (6) @(posedge ref_clk);
		bus(1'h0, 4'h0, 32'h0);
		chk("refuse", rd, 32'h8110);
		chk("banked", {24'h0, mem[12'h310]}, 32'h0b);
		$display("refuse done");
		end_sim;
	end
endmodule : bit_set_file_instruction_test
